// ### bgtm_counter.v
// Purpose: pixel and line counters on the synchronised sync and enable of one port
// Assumes: one pixel per I_CLK cycle, sync pulses active high
// Notes: produces a pulse with one field of counts at each field end
`timescale 1ns/10ps
module bgtm_counter (
    input wire i_clk,
    input wire i_rst_b,
    input wire i_run,
    input wire i_new_mode,
    input wire i_hs,
    input wire i_vs,
    input wire i_de,
    input wire i_field,
    output reg o_field_end,
    output reg [13:0] o_tot_pix,
    output reg [12:0] o_act_pix,
    output reg [12:0] o_tot_lin,
    output reg [12:0] o_act_lin,
    output reg o_ilace
);
    reg hs_q;
    reg vs_q;
    reg de_q;
    reg fld_q;
    reg de_line_q;
    reg seen_vs_q;
    reg [13:0] pix_q;
    reg [12:0] act_q;
    reg [12:0] lin_q;
    reg [12:0] alin_q;
    wire hs_rise;
    wire vs_edge;
    assign hs_rise = i_hs & ~hs_q;
    // new mode takes the trailing sync edge, which suits slow frame rates
    assign vs_edge = i_new_mode ? (~i_vs & vs_q) : (i_vs & ~vs_q);
    // counting of pixels per line and lines per field
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hs_q <= 1'b0;
            vs_q <= 1'b0;
            de_q <= 1'b0;
            fld_q <= 1'b0;
            de_line_q <= 1'b0;
            seen_vs_q <= 1'b0;
            pix_q <= 14'h0000;
            act_q <= 13'h0000;
            lin_q <= 13'h0000;
            alin_q <= 13'h0000;
            o_field_end <= 1'b0;
            o_tot_pix <= 14'h0000;
            o_act_pix <= 13'h0000;
            o_tot_lin <= 13'h0000;
            o_act_lin <= 13'h0000;
            o_ilace <= 1'b0;
        end else begin
            hs_q <= i_hs;
            vs_q <= i_vs;
            de_q <= i_de;
            o_field_end <= 1'b0;
            if (!i_run) begin
                seen_vs_q <= 1'b0;
                pix_q <= 14'h0000;
                act_q <= 13'h0000;
                lin_q <= 13'h0000;
                alin_q <= 13'h0000;
            end else begin
                if (hs_rise) begin
                    o_tot_pix <= pix_q;
                    if (act_q != 13'h0000) begin
                        o_act_pix <= act_q;
                    end
                    pix_q <= 14'h0001;
                    act_q <= {12'h000, i_de};
                    lin_q <= lin_q + 13'h0001;
                    alin_q <= alin_q + {12'h000, de_line_q};
                    de_line_q <= 1'b0;
                end else begin
                    pix_q <= pix_q + 14'h0001;
                    act_q <= act_q + {12'h000, i_de};
                    if (de_q) begin
                        de_line_q <= 1'b1;
                    end
                end
                if (vs_edge) begin
                    seen_vs_q <= 1'b1;
                    lin_q <= {12'h000, hs_rise}; // a line starting on this edge opens the new field
                    alin_q <= 13'h0000;
                    fld_q <= i_field;
                    if (seen_vs_q) begin
                        o_tot_lin <= lin_q;
                        o_act_lin <= alin_q + {12'h000, hs_rise & de_line_q}; // closing line ends here
                        o_ilace <= (i_field != fld_q);
                        o_field_end <= 1'b1;
                    end
                end
            end
        end
    end
endmodule

// ### bgtm_map.vh
// Purpose: register offsets, field positions, reset values and timing counts of the background timing measure
// Assumes: byte-wide register port, offsets are byte addresses of the register map
// Notes: high-byte registers hold the upper bits of each split count
`ifndef BGTM_MAP_VH
`define BGTM_MAP_VH
`define BGTM_OFF_CTRL 8'h4C
`define BGTM_OFF_MEAS 8'hEB
`define BGTM_OFF_ACT_PIX_HI 8'hE2
`define BGTM_OFF_ACT_PIX_LO 8'hE3
`define BGTM_OFF_TOT_PIX_HI 8'hE4
`define BGTM_OFF_TOT_PIX_LO 8'hE5
`define BGTM_OFF_ACT_LIN_HI 8'hE6
`define BGTM_OFF_ACT_LIN_LO 8'hE7
`define BGTM_OFF_TOT_LIN_HI 8'hE8
`define BGTM_OFF_TOT_LIN_LO 8'hE9
`define BGTM_OFF_STAT 8'hEA
`define BGTM_BIT_VMODE 2
`define BGTM_BIT_REQ 0
`define BGTM_BIT_DONE 7
`define BGTM_BIT_ILACE 0
`define BGTM_BIT_LOCK 1
`define BGTM_POS_PORT 4
`define BGTM_RST_CTRL 8'h00
`define BGTM_RST_PORT 3'h0
`define BGTM_NUM_PORTS 4
`define BGTM_LOCK_FIELDS 2
`endif

// ### bgtm_sync.v
// Purpose: three-stage synchroniser for one pin-level input
// Assumes: input is asynchronous to I_CLK
// Notes: output changes only once stages two and three agree
`timescale 1ns/10ps
module bgtm_sync (
    input wire i_clk,
    input wire i_rst_b,
    input wire i_async,
    output reg o_level
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    // shift chain plus agreement filter
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            o_level <= 1'b0;
        end else begin
            s1_q <= i_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                o_level <= s3_q;
            end
        end
    end
endmodule

// ### bgtm_top.v
// Purpose: background port video timing measurement with byte-wide register port
// Assumes: sync inputs of each port arrive from outside the clock domain
// Notes: results are replaced only when a requested measurement completes
// Overview of operation
// - measurements use the port chosen by the three-bit port select field
// - lock flag reads 1 when timing was stable during the measurement
// - total pixels per line reported as fourteen bits over two bytes
// - active pixels per line reported as thirteen bits
// - total lines per field reported as thirteen bits
// - active lines per field reported as thirteen bits
// - interlace bit reads 0 progressive, 1 interlaced
// - results update only after a software measurement request
// - read-write bit selects the newer vertical extraction method
// - select port, raise request, device raises done when results are readable
`timescale 1ns/10ps
`include "bgtm_map.vh"
module bgtm_top (
    // clock and reset
    input wire I_CLK,
    input wire I_RST_B,
    // register port
    input wire I_REG_WR,
    input wire I_REG_RD,
    input wire [7:0] I_REG_ADDR,
    input wire [7:0] I_REG_WDATA,
    output reg [7:0] O_REG_RDATA,
    output reg O_REG_RVALID,
    // video port pins, one bit per port
    input wire [3:0] I_PORT_HSYNC,
    input wire [3:0] I_PORT_VSYNC,
    input wire [3:0] I_PORT_DE,
    input wire [3:0] I_PORT_FIELD,
    // status
    output reg O_MEASURE_DONE
);
    localparam ST_IDLE = 3'b001;
    localparam ST_MEAS = 3'b010;
    localparam ST_DONE = 3'b100;

    // sequencer state
    reg [2:0] state_q;
    reg [2:0] state_d;
    // control fields written by software, and the done flag set by hardware
    reg vertical_extract_mode_q;
    reg [2:0] background_port_select_q;
    reg measure_request_q;
    reg measure_done_flag_q;
    // held results, replaced only at completion
    reg [13:0] total_line_pixels_q;
    reg [12:0] active_line_pixels_q;
    reg [12:0] total_field_lines_q;
    reg [12:0] active_field_lines_q;
    reg interlace_flag_q;
    reg timing_lock_flag_q;
    // field count and lock tracking
    reg [1:0] fields_q;
    reg stable_q;
    reg [13:0] prev_pix_q;
    reg [12:0] prev_lin_q;
    // read data before its output register
    reg [7:0] rdata_d;
    // synchronised pins of every port
    wire [3:0] hs_s;
    wire [3:0] vs_s;
    wire [3:0] de_s;
    wire [3:0] fld_s;
    // lines of the selected port
    reg sel_hs;
    reg sel_vs;
    reg sel_de;
    reg sel_fld;
    // counter results
    wire run;
    wire fend;
    wire [13:0] c_tot_pix;
    wire [12:0] c_act_pix;
    wire [12:0] c_tot_lin;
    wire [12:0] c_act_lin;
    wire c_ilace;
    // sequencer events and register decodes
    wire start;
    wire finish;
    wire last_field;
    wire fields_match;
    wire wr_ctrl;
    wire wr_meas;

    // synchronise every sync pin of every port
    genvar g;
    generate
        for (g = 0; g < `BGTM_NUM_PORTS; g = g + 1) begin : g_port
            bgtm_sync u_hs (
                .i_clk(I_CLK),
                .i_rst_b(I_RST_B),
                .i_async(I_PORT_HSYNC[g]),
                .o_level(hs_s[g])
            );
            bgtm_sync u_vs (
                .i_clk(I_CLK),
                .i_rst_b(I_RST_B),
                .i_async(I_PORT_VSYNC[g]),
                .o_level(vs_s[g])
            );
            bgtm_sync u_de (
                .i_clk(I_CLK),
                .i_rst_b(I_RST_B),
                .i_async(I_PORT_DE[g]),
                .o_level(de_s[g])
            );
            bgtm_sync u_fld (
                .i_clk(I_CLK),
                .i_rst_b(I_RST_B),
                .i_async(I_PORT_FIELD[g]),
                .o_level(fld_s[g])
            );
        end
    endgenerate

    // port mux; selects beyond the last port see idle lines
    // so a select of four or more never completes a run
    always @* begin
        sel_hs = 1'b0;
        sel_vs = 1'b0;
        sel_de = 1'b0;
        sel_fld = 1'b0;
        if (background_port_select_q < 3'h4) begin
            sel_hs = hs_s[background_port_select_q[1:0]];
            sel_vs = vs_s[background_port_select_q[1:0]];
            sel_de = de_s[background_port_select_q[1:0]];
            sel_fld = fld_s[background_port_select_q[1:0]];
        end
    end

    // counters run only while a measurement is open
    assign run = state_q[1];

    // counters on the chosen port
    bgtm_counter u_cnt (
        .i_clk(I_CLK),
        .i_rst_b(I_RST_B),
        .i_run(run),
        .i_new_mode(vertical_extract_mode_q),
        .i_hs(sel_hs),
        .i_vs(sel_vs),
        .i_de(sel_de),
        .i_field(sel_fld),
        .o_field_end(fend),
        .o_tot_pix(c_tot_pix),
        .o_act_pix(c_act_pix),
        .o_tot_lin(c_tot_lin),
        .o_act_lin(c_act_lin),
        .o_ilace(c_ilace)
    );

    // a request starts a run only from idle, so it must drop between runs
    assign start = state_q[0] & measure_request_q;
    assign finish = run & fend & last_field;

    // second field of the pair closes the measurement
    assign last_field = ({30'h00000000, fields_q} == (`BGTM_LOCK_FIELDS - 1));
    // both fields agree on line length and field height
    assign fields_match = (prev_pix_q == c_tot_pix) && (prev_lin_q == c_tot_lin);

    // register write decodes
    assign wr_ctrl = I_REG_WR && (I_REG_ADDR == `BGTM_OFF_CTRL);
    assign wr_meas = I_REG_WR && (I_REG_ADDR == `BGTM_OFF_MEAS);

    // measurement sequencer
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (start) begin
                    state_d = ST_MEAS;
                end
            end
            ST_MEAS: begin
                if (finish) begin
                    state_d = ST_DONE;
                end
            end
            ST_DONE: begin
                if (!measure_request_q) begin
                    state_d = ST_IDLE; // request must drop before a new run
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // state, field count and stability tracking
    always @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            state_q <= ST_IDLE;
            fields_q <= 2'h0;
            stable_q <= 1'b1;
            prev_pix_q <= 14'h0000;
            prev_lin_q <= 13'h0000;
        end else begin
            state_q <= state_d;
            if (start) begin
                fields_q <= 2'h0;
                stable_q <= 1'b1;
            end else if (run && fend) begin
                fields_q <= fields_q + 2'h1;
                prev_pix_q <= c_tot_pix;
                prev_lin_q <= c_tot_lin;
                // any field differing from the one before breaks the lock
                if (fields_q != 2'h0 && !fields_match) begin
                    stable_q <= 1'b0;
                end
            end
        end
    end

    // result registers, replaced only at completion
    always @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            total_line_pixels_q <= 14'h0000;
            active_line_pixels_q <= 13'h0000;
            total_field_lines_q <= 13'h0000;
            active_field_lines_q <= 13'h0000;
            interlace_flag_q <= 1'b0;
            timing_lock_flag_q <= 1'b0;
        end else if (finish) begin
            total_line_pixels_q <= c_tot_pix;
            active_line_pixels_q <= c_act_pix;
            total_field_lines_q <= c_tot_lin;
            active_field_lines_q <= c_act_lin;
            interlace_flag_q <= c_ilace;
            timing_lock_flag_q <= stable_q && fields_match;
        end
    end

    // control register writes
    always @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            vertical_extract_mode_q <= 1'b0;
            background_port_select_q <= `BGTM_RST_PORT;
            measure_request_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                vertical_extract_mode_q <= I_REG_WDATA[`BGTM_BIT_VMODE];
            end
            if (wr_meas) begin
                background_port_select_q <= I_REG_WDATA[`BGTM_POS_PORT+2:`BGTM_POS_PORT];
                measure_request_q <= I_REG_WDATA[`BGTM_BIT_REQ];
            end
        end
    end

    // done flag: completion sets it, a new start clears it, set wins
    always @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            measure_done_flag_q <= 1'b0;
        end else if (finish) begin
            measure_done_flag_q <= 1'b1;
        end else if (start) begin
            measure_done_flag_q <= 1'b0;
        end
    end

    // read data mux
    always @* begin
        rdata_d = 8'h00;
        case (I_REG_ADDR)
            `BGTM_OFF_CTRL: rdata_d[`BGTM_BIT_VMODE] = vertical_extract_mode_q;
            `BGTM_OFF_MEAS: begin
                rdata_d[`BGTM_POS_PORT+2:`BGTM_POS_PORT] = background_port_select_q;
                rdata_d[`BGTM_BIT_REQ] = measure_request_q;
                rdata_d[`BGTM_BIT_DONE] = measure_done_flag_q;
            end
            `BGTM_OFF_ACT_PIX_HI: rdata_d = {3'h0, active_line_pixels_q[12:8]};
            `BGTM_OFF_ACT_PIX_LO: rdata_d = active_line_pixels_q[7:0];
            `BGTM_OFF_TOT_PIX_HI: rdata_d = {2'h0, total_line_pixels_q[13:8]};
            `BGTM_OFF_TOT_PIX_LO: rdata_d = total_line_pixels_q[7:0];
            `BGTM_OFF_ACT_LIN_HI: rdata_d = {3'h0, active_field_lines_q[12:8]};
            `BGTM_OFF_ACT_LIN_LO: rdata_d = active_field_lines_q[7:0];
            `BGTM_OFF_TOT_LIN_HI: rdata_d = {3'h0, total_field_lines_q[12:8]};
            `BGTM_OFF_TOT_LIN_LO: rdata_d = total_field_lines_q[7:0];
            `BGTM_OFF_STAT: begin
                rdata_d[`BGTM_BIT_LOCK] = timing_lock_flag_q;
                rdata_d[`BGTM_BIT_ILACE] = interlace_flag_q;
            end
            default: rdata_d = 8'h00;
        endcase
    end

    // registered read answer and done output
    always @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_REG_RDATA <= 8'h00;
            O_REG_RVALID <= 1'b0;
            O_MEASURE_DONE <= 1'b0;
        end else begin
            O_REG_RVALID <= I_REG_RD;
            if (I_REG_RD) begin
                O_REG_RDATA <= rdata_d;
            end
            O_MEASURE_DONE <= measure_done_flag_q;
        end
    end
endmodule

// ### bgtm_top_assertions.sv
// Purpose: port-level checks of the background timing measure
// Assumes: register reads answer one cycle after the strobe
// Notes: helper copies track the written control bits
`timescale 1ns/10ps
`include "bgtm_map.vh"
module bgtm_top_chk (
    // watched ports
    input logic I_CLK,
    input logic I_RST_B,
    input logic I_REG_WR,
    input logic I_REG_RD,
    input logic [7:0] I_REG_ADDR,
    input logic [7:0] I_REG_WDATA,
    input logic [7:0] O_REG_RDATA,
    input logic O_REG_RVALID,
    input logic O_MEASURE_DONE
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);
    logic [7:0] ctrl_q;
    logic mode_q;
    logic mapped;
    // shadow of the written control bits
    always @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            ctrl_q <= 8'h00;
            mode_q <= 1'b0;
        end else if (I_REG_WR) begin
            if (I_REG_ADDR == `BGTM_OFF_MEAS) ctrl_q <= I_REG_WDATA & 8'h71;
            if (I_REG_ADDR == `BGTM_OFF_CTRL) mode_q <= I_REG_WDATA[2];
        end
    end
    assign mapped = (I_REG_ADDR == `BGTM_OFF_CTRL) || (I_REG_ADDR >= 8'hE2 && I_REG_ADDR <= 8'hEB);
    rvalid_after_rd_a: assert property (I_REG_RD |=> O_REG_RVALID)
        else $error("read gave no answer");
    rvalid_cause_a: assert property (O_REG_RVALID |-> $past(I_REG_RD))
        else $error("answer without read");
    rdata_held_a: assert property (!O_REG_RVALID |-> $stable(O_REG_RDATA))
        else $error("read data moved without read");
    unmapped_zero_a: assert property (I_REG_RD && !mapped |=> O_REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    count_pad_a: assert property (I_REG_RD && (I_REG_ADDR == 8'hE2 || I_REG_ADDR == 8'hE6 || I_REG_ADDR == 8'hE8)
        |=> O_REG_RDATA[7:5] == 3'h0) else $error("count high bits not zero");
    tot_pix_pad_a: assert property (I_REG_RD && I_REG_ADDR == 8'hE4 |=> O_REG_RDATA[7:6] == 2'h0)
        else $error("total pixel high bits not zero");
    status_pad_a: assert property (I_REG_RD && I_REG_ADDR == 8'hEA |=> O_REG_RDATA[7:2] == 6'h00)
        else $error("status spare bits not zero");
    mode_readback_a: assert property (I_REG_RD && !I_REG_WR && I_REG_ADDR == 8'h4C
        |=> O_REG_RDATA == {5'h00, mode_q, 2'h0}) else $error("mode bit readback wrong");
    ctrl_readback_a: assert property (I_REG_RD && !I_REG_WR && I_REG_ADDR == 8'hEB
        |=> O_REG_RDATA[6:0] == ctrl_q[6:0]) else $error("control readback wrong");
    done_clears_a: assert property (I_REG_WR && I_REG_ADDR == 8'hEB && I_REG_WDATA[0] && !ctrl_q[0]
        |-> ##[1:5] !O_MEASURE_DONE) else $error("done not cleared by new run");
    done_needs_req_a: assert property ($rose(O_MEASURE_DONE) |-> $past(ctrl_q[0], 2))
        else $error("done without request");
endmodule
bind bgtm_top bgtm_top_chk u_chk (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_REG_WR(I_REG_WR),
    .I_REG_RD(I_REG_RD), .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA),
    .O_REG_RDATA(O_REG_RDATA), .O_REG_RVALID(O_REG_RVALID), .O_MEASURE_DONE(O_MEASURE_DONE));

// ### bgtm_vsrc.sv
// Purpose: video source model driving one background port
// Assumes: one pixel per clock, active-high syncs
// Notes: unselected ports stay idle low; jitter lengthens odd fields by a line
`timescale 1ns/10ps
module bgtm_vsrc #(
    parameter HT = 40,
    parameter HA = 32,
    parameter VT = 12,
    parameter VA = 8
) (
    // control from the bench
    input wire i_clk,
    input wire [1:0] i_port,
    input wire i_ilace,
    input wire i_jit,
    // video pins
    output wire [3:0] o_hs,
    output wire [3:0] o_vs,
    output wire [3:0] o_de,
    output wire [3:0] o_fld
);
    integer px = 0;
    integer ln = 0;
    reg odd = 1'b0;
    reg hs;
    reg vs;
    reg de;
    // raster position, moved off the sampling edge
    always @(negedge i_clk) begin
        if (px == HT - 1) begin
            px <= 0;
            if (ln >= VT - 1 + (i_jit & odd)) begin // jitter dropped mid-field must not strand the raster
                ln <= 0;
                odd <= ~odd;
            end else begin
                ln <= ln + 1;
            end
        end else begin
            px <= px + 1;
        end
    end
    // sync and enable shapes
    always @* begin
        hs = (px < 2);
        vs = (ln < 2);
        de = (px >= HT - HA) && (ln >= VT - VA);
    end
    // route onto the chosen port only
    assign o_hs = {3'h0, hs} << i_port;
    assign o_vs = {3'h0, vs} << i_port;
    assign o_de = {3'h0, de} << i_port;
    assign o_fld = {3'h0, i_ilace & odd} << i_port;
endmodule

// ### testbench.sv
// Purpose: register-level tests of the background timing measure
// Assumes: source raster 40 by 12, 32 by 8 active
// Notes: inputs change at the falling edge
`timescale 1ns/10ps
`include "bgtm_map.vh"
module testbench;
    reg clk;
    reg rst_b = 1'b0;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg [7:0] addr = 8'h00;
    reg [7:0] wdata = 8'h00;
    reg [1:0] vport = 2'h1;
    reg ilace = 1'b0;
    reg jit = 1'b0;
    reg [7:0] rv;
    reg [7:0] hb;
    wire [7:0] rdata;
    wire rvalid;
    wire done;
    wire [3:0] hs, vs, de, fld;
    integer n_fail = 0;
    integer n_compared = 0;
    bgtm_top u_bgtm_top (.I_CLK(clk), .I_RST_B(rst_b), .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_ADDR(addr),
        .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid), .I_PORT_HSYNC(hs),
        .I_PORT_VSYNC(vs), .I_PORT_DE(de), .I_PORT_FIELD(fld), .O_MEASURE_DONE(done));
    bgtm_vsrc u_bgtm_vsrc (.i_clk(clk), .i_port(vport), .i_ilace(ilace), .i_jit(jit),
        .o_hs(hs), .o_vs(vs), .o_de(de), .o_fld(fld));
    // free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task check(input [15:0] seen, input [15:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wr_reg(input [7:0] a, input [7:0] d);
        begin
            @(negedge clk);
            addr = a;
            wdata = d;
            wr = 1'b1;
            @(negedge clk);
            wr = 1'b0;
        end
    endtask
    task rd_reg(input [7:0] a);
        integer k;
        begin
            @(negedge clk);
            addr = a;
            rd = 1'b1;
            @(negedge clk);
            rd = 1'b0;
            k = 0;
            while (rvalid !== 1'b1 && k < 4) begin
                @(negedge clk);
                k = k + 1;
            end
            rv = rdata;
        end
    endtask
    task rchk(input [7:0] a, input [7:0] e);
        begin
            rd_reg(a);
            check({8'h00, rv}, {8'h00, e});
        end
    endtask
    // high byte at a, low byte at a plus one
    task pchk(input [7:0] a, input [15:0] e);
        begin
            rd_reg(a);
            hb = rv;
            rd_reg(a + 8'h01);
            check({hb, rv}, e);
        end
    endtask
    task wait_done;
        integer k;
        begin
            repeat (4) @(negedge clk);
            k = 0;
            while (done !== 1'b1 && k < 6000) begin
                @(negedge clk);
                k = k + 1;
            end
            check({15'h0000, done}, 16'h0001);
        end
    endtask
    task close_out;
        begin
            if (n_fail == 0 && n_compared > 0) begin
                $display("All checks passed");
            end else begin
                $display("Checks failed");
            end
            $finish;
        end
    endtask
    // hang guard, well beyond the expected run
    initial begin
        #400000;
        n_fail = n_fail + 1;
        close_out;
    end
    initial begin
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        rchk(`BGTM_OFF_CTRL, `BGTM_RST_CTRL);
        rchk(`BGTM_OFF_MEAS, 8'h00);
        rchk(`BGTM_OFF_STAT, 8'h00);
        pchk(`BGTM_OFF_TOT_PIX_HI, 16'h0000);
        wr_reg(8'h10, 8'hFF);
        rchk(8'h10, 8'h00);
        wr_reg(`BGTM_OFF_TOT_PIX_LO, 8'hFF);
        rchk(`BGTM_OFF_TOT_PIX_LO, 8'h00);
        wr_reg(`BGTM_OFF_CTRL, 8'hFF);
        rchk(`BGTM_OFF_CTRL, 8'h04);
        wr_reg(`BGTM_OFF_CTRL, 8'h00);
        // progressive source on port 1
        wr_reg(`BGTM_OFF_MEAS, 8'h11);
        wait_done;
        rchk(`BGTM_OFF_MEAS, 8'h91);
        pchk(`BGTM_OFF_TOT_PIX_HI, 16'd40);
        pchk(`BGTM_OFF_ACT_PIX_HI, 16'd32);
        pchk(`BGTM_OFF_TOT_LIN_HI, 16'd12);
        pchk(`BGTM_OFF_ACT_LIN_HI, 16'd8);
        rchk(`BGTM_OFF_STAT, 8'h02);
        // source turns interlaced without a request
        wr_reg(`BGTM_OFF_MEAS, 8'h10);
        ilace = 1'b1;
        repeat (1500) @(negedge clk);
        rchk(`BGTM_OFF_STAT, 8'h02);
        check({15'h0000, done}, 16'h0001);
        // interlaced run with the newer vertical extraction
        wr_reg(`BGTM_OFF_CTRL, 8'h04);
        wr_reg(`BGTM_OFF_MEAS, 8'h11);
        wait_done;
        rchk(`BGTM_OFF_STAT, 8'h03);
        pchk(`BGTM_OFF_TOT_LIN_HI, 16'd12);
        // fields of unequal height must not lock
        wr_reg(`BGTM_OFF_CTRL, 8'h00);
        wr_reg(`BGTM_OFF_MEAS, 8'h10);
        ilace = 1'b0;
        jit = 1'b1;
        wr_reg(`BGTM_OFF_MEAS, 8'h11);
        wait_done;
        rchk(`BGTM_OFF_STAT, 8'h00);
        // selected port 2 is idle, so no completion
        jit = 1'b0;
        wr_reg(`BGTM_OFF_MEAS, 8'h20);
        wr_reg(`BGTM_OFF_MEAS, 8'h21);
        repeat (3000) @(negedge clk);
        check({15'h0000, done}, 16'h0000);
        pchk(`BGTM_OFF_TOT_PIX_HI, 16'd40);
        // source moves to port 2
        vport = 2'h2;
        wait_done;
        rchk(`BGTM_OFF_STAT, 8'h02);
        pchk(`BGTM_OFF_ACT_PIX_HI, 16'd32);
        close_out;
    end
endmodule
